// File: verilog/sfft_map.svh
/*
  Address map, field positions, reset values and timing counts
  of the free-format serial transfer block. Assumes a 40 MHz core clock.
*/
// Contract
// - Format word sets framing and bit rate
// - Bit 8 prefixes the start character
// - Bit 9 appends the stop character
// - Send during reception raises send waiting
// - Send request transmits, clears at completion
// - Complete flag set; clearing rearms reception
// - Pause beyond timeout ends reception, flags it
// - Clearing complete also clears timeout flag
// - Timeout is setting times 10 ms; settings below 5 give 50 ms
// - Timeout ends reception without stop character
// - Enabling the function enters receive waiting
// - Readable remaining-send and received byte counts
// - Word mode: low byte first, ascending
// - Frame: start char, data bytes, stop char
// - Card port has its own full copy
// - Zero receive length never waits or completes
// - Byte mode uses only low byte
// - Format latched at activation, later writes ignored
`ifndef SFFT_MAP_SVH
`define SFFT_MAP_SVH
`define CLK_HZ           40000000
`define TICK_MS          10
`define TIMEOUT_MIN      8'h05
`define TIMEOUT_FALLBACK 8'h05
`define FORMAT_RST       16'h0000
`define START_CHAR_RST   8'h02
`define STOP_CHAR_RST    8'h03
`define TIMEOUT_RST      8'h05
`define OFS_FORMAT       12'h000
`define OFS_CONTROL      12'h004
`define OFS_STATUS       12'h008
`define OFS_SEND_LEN     12'h00C
`define OFS_RECV_LEN     12'h010
`define OFS_SEND_REM     12'h014
`define OFS_RECV_CNT     12'h018
`define OFS_START_CHAR   12'h01C
`define OFS_STOP_CHAR    12'h020
`define OFS_TIMEOUT      12'h024
`define AREA_TX          2'b01
`define AREA_RX          2'b10
`define CTL_ENABLE       0
`define CTL_SEND_REQ     1
`define CTL_BYTE_MODE    2
`define ST_RX_DONE       2
`endif

// File: verilog/sfft_pkg.sv
/*
  Types and shared helpers of the free-format serial transfer block.
  Assumes the constants header is on the include path.
*/
package sfft_pkg;
  `include "sfft_map.svh"

  typedef struct packed {
    logic [5:0] reserved;
    logic       stop_char_en;
    logic       start_char_en;
    logic [3:0] rate;
    logic       two_stop;
    logic [1:0] parity;
    logic       eight_bits;
  } format_type;

  typedef enum logic [1:0] {RX_OFF, RX_WAIT, RX_BUSY, RX_DONE} rx_state_type;
  typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_BODY, TX_TRAIL, TX_DRAIN} tx_phase_type;

  // Cycles per bit for each rate code; unknown codes fall to 9600
  function automatic logic [12:0] bit_cycles(input logic [3:0] rate);
    case (rate)
      4'h8:    bit_cycles = 13'(`CLK_HZ / 19200);
      4'h9:    bit_cycles = 13'(`CLK_HZ / 38400);
      4'hA:    bit_cycles = 13'(`CLK_HZ / 57600);
      4'hB:    bit_cycles = 13'(`CLK_HZ / 76800);
      4'hC:    bit_cycles = 13'(`CLK_HZ / 128000);
      4'hD:    bit_cycles = 13'(`CLK_HZ / 153600);
      4'hE:    bit_cycles = 13'(`CLK_HZ / 307200);
      default: bit_cycles = 13'(`CLK_HZ / 9600);
    endcase
  endfunction

  // Parity enabled for odd or even codes only
  function automatic logic has_parity(input format_type f);
    has_parity = (f.parity == 2'b01) || (f.parity == 2'b10);
  endfunction

  // Start, data and parity bits plus the first stop bit
  function automatic logic [3:0] frame_bits(input format_type f);
    frame_bits = 4'd2 + (f.eight_bits ? 4'd8 : 4'd7) + {3'd0, has_parity(f)};
  endfunction

  // Parity bit value for the data actually on the line
  function automatic logic parity_bit(input format_type f, input logic [7:0] d);
    parity_bit = (^d) ^ (f.parity == 2'b01);
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction
endpackage

// File: verilog/char_link_if.sv
/*
  Character link between the port sequencer and its line cores.
  Assumes one clock domain shared by all parties.
*/
`timescale 1ns/10ps
`default_nettype none
interface char_link_if;
  import sfft_pkg::*;
  format_type  fmt;
  logic [12:0] period;
  logic        tx_go;
  logic [7:0]  tx_byte;
  logic        tx_busy;
  logic        tx_done;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_err;
  modport ctl (output fmt, period, tx_go, tx_byte,
               input tx_busy, tx_done, rx_valid, rx_byte, rx_err);
  modport tx (input fmt, period, tx_go, tx_byte, output tx_busy, tx_done);
  modport rx (input fmt, period, output rx_valid, rx_byte, rx_err);
endinterface
`default_nettype wire

// File: verilog/char_tx.sv
/*
  Serialiser for one character on the line.
  Assumes tx_go only while tx_busy is low and format stable meanwhile.
*/
`timescale 1ns/10ps
`default_nettype none
module char_tx (
  input  wire logic core_clk_i, // Core clock
  input  wire logic nrst_i,     // Async reset, low
  char_link_if.tx   link,       // Character link
  output var  logic txd_o       // Serial line out
);
  import sfft_pkg::*;

  logic [11:0] shreg;
  logic [3:0]  bits_left;
  logic [12:0] tmr;
  logic [7:0]  data_m;
  logic [11:0] frame;
  logic [3:0]  len;

  // Frame image, start bit at bit 0, ones fill the stop tail
  assign data_m = link.fmt.eight_bits ? link.tx_byte : {1'b0, link.tx_byte[6:0]};
  assign len    = frame_bits(link.fmt) + {3'd0, link.fmt.two_stop};
  always_comb begin
    frame      = 12'hFFF;
    frame[0]   = 1'b0;
    frame[8:1] = data_m;
    if (!link.fmt.eight_bits) frame[8] = 1'b1;
    if (has_parity(link.fmt)) frame[link.fmt.eight_bits ? 9 : 8] = parity_bit(link.fmt, data_m);
  end

  // Bit timer and shifter, LSB first
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shreg <= 12'hFFF; bits_left <= 4'h0; tmr <= 13'h0000;
      txd_o <= 1'b1; link.tx_busy <= 1'b0; link.tx_done <= 1'b0;
    end else begin
      link.tx_done <= 1'b0;
      if (!link.tx_busy) begin
        if (link.tx_go) begin
          txd_o <= frame[0];
          shreg <= frame >> 1;
          bits_left <= len - 4'd1;
          tmr <= link.period - 13'd1;
          link.tx_busy <= 1'b1;
        end
      end else if (tmr != 13'h0000) begin
        tmr <= tmr - 13'd1;
      end else if (bits_left != 4'h0) begin
        txd_o <= shreg[0];
        shreg <= shreg >> 1;
        bits_left <= bits_left - 4'd1;
        tmr <= link.period - 13'd1;
      end else begin
        link.tx_busy <= 1'b0;
        link.tx_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/char_rx.sv
/*
  Deserialiser for one character from the line.
  Assumes the line idles high; glitched start bits are dropped.
*/
`timescale 1ns/10ps
`default_nettype none
module char_rx (
  input  wire logic core_clk_i, // Core clock
  input  wire logic nrst_i,     // Async reset, low
  input  wire logic rxd_i,      // Serial line in, async
  char_link_if.rx   link        // Character link
);
  import sfft_pkg::*;

  logic        s1, s2, s3, line;
  logic        busy, fin;
  logic [12:0] tmr;
  logic [3:0]  idx;
  logic [11:0] cap;
  logic [7:0]  dat;
  logic [3:0]  par_pos;

  // Three-stage synchroniser; level moves only when stages two and three agree
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= 1'b1; s2 <= 1'b1; s3 <= 1'b1; line <= 1'b1;
    end else begin
      s1 <= rxd_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) line <= s3;
    end
  end

  assign dat     = link.fmt.eight_bits ? cap[8:1] : {1'b0, cap[7:1]};
  assign par_pos = link.fmt.eight_bits ? 4'd9 : 4'd8;

  // Mid-bit sampling, then a one-cycle result
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy <= 1'b0; fin <= 1'b0; tmr <= 13'h0000; idx <= 4'h0; cap <= 12'h000;
      link.rx_valid <= 1'b0; link.rx_byte <= 8'h00; link.rx_err <= 1'b0;
    end else begin
      link.rx_valid <= fin;
      fin <= 1'b0;
      if (fin) begin
        link.rx_byte <= dat;
        link.rx_err  <= !cap[frame_bits(link.fmt) - 4'd1] ||
                        (has_parity(link.fmt) && cap[par_pos] != parity_bit(link.fmt, dat));
      end
      if (!busy) begin
        if (!line) begin
          busy <= 1'b1;
          idx  <= 4'h0;
          tmr  <= link.period >> 1;
        end
      end else if (tmr != 13'h0000) begin
        tmr <= tmr - 13'd1;
      end else if (idx == 4'h0 && line) begin
        busy <= 1'b0; // Start bit did not hold
      end else begin
        cap[idx] <= line;
        idx <= idx + 4'd1;
        tmr <= link.period - 13'd1;
        if (idx == frame_bits(link.fmt) - 4'd1) begin
          busy <= 1'b0;
          fin  <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/serial_free_format_transfer.sv
/*
  Free-format serial transfer: two independent ports (main and card)
  with format, counts, characters, timeout and data areas on a
  classic Wishbone slave. Assumes a single-cycle classic master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sfft_map.svh"
module serial_free_format_transfer #(
  parameter int unsigned TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS // Cycles per 10 ms
) (
  input  wire logic        core_clk_i, // Core clock, 40 MHz
  input  wire logic        nrst_i,     // Async reset, low
  input  wire logic        wb_cyc_i,   // Bus cycle
  input  wire logic        wb_stb_i,   // Bus strobe
  input  wire logic        wb_we_i,    // Write enable
  input  wire logic [12:0] wb_adr_i,   // Byte address
  input  wire logic [31:0] wb_dat_i,   // Write data
  input  wire logic [3:0]  wb_sel_i,   // Byte lanes
  output var  logic [31:0] wb_dat_o,   // Read data
  output var  logic        wb_ack_o,   // Acknowledge
  input  wire logic [1:0]  rxd_i,      // Line in, main and card
  output var  logic [1:0]  txd_o,      // Line out, main and card
  output var  logic [1:0]  drive_en_o  // Line driver enable
);
  import sfft_pkg::*;

  logic        req;
  logic        wr_fire;
  logic        port_sel;
  logic [11:0] loc;
  logic [7:0]  widx;
  logic [31:0] port_rd [2];

  // Bus decode; a write lands on the edge that samples ack
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_fire  = req & wb_we_i & wb_ack_o;
  assign port_sel = wb_adr_i[12];
  assign loc      = wb_adr_i[11:0];
  assign widx     = loc[9:2];

  // One wait state; unmapped reads return zero
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) wb_dat_o <= port_rd[port_sel];
    end
  end

  // Each port is a full independent copy
  for (genvar p = 0; p < 2; p++) begin : g_port
    char_link_if link ();

    format_type   fmt_reg, fmt_live;
    logic         enable, en_q, byte_mode;
    logic         send_req, send_wait, timed_out, pend;
    logic [7:0]   send_len, recv_len, send_rem, recv_cnt;
    logic [7:0]   start_ch, stop_ch, tmo_set, tx_idx;
    logic [18:0]  presc;
    logic [7:0]   ticks;
    rx_state_type rx_state;
    tx_phase_type tx_phase;
    logic [15:0]  tx_mem [256];
    logic [7:0]   rx_lo [256];
    logic [7:0]   rx_hi [256];

    logic        hit, wr_fmt, wr_ctl, wr_st, act;
    logic        req_set, rx_ok, can_issue, tx_start, clr_done;
    logic [7:0]  tmo_lim, tx_pick;
    logic [15:0] tx_word;
    logic [15:0] wd;

    assign hit    = wr_fire && (port_sel == 1'(p));
    assign wd     = wb_dat_i[15:0];
    assign wr_fmt = hit && loc == `OFS_FORMAT;
    assign wr_ctl = hit && loc == `OFS_CONTROL;
    assign wr_st  = hit && loc == `OFS_STATUS;
    assign act    = enable && !en_q;
    // Only a waiting or finished port may take a send; busy defers it
    assign req_set  = wr_ctl && wb_sel_i[0] && wd[`CTL_SEND_REQ] && rx_state != RX_OFF;
    assign clr_done = wr_st && wb_sel_i[0] && wd[`ST_RX_DONE] && rx_state == RX_DONE;
    // Own echo is ignored while this end drives the line
    assign rx_ok  = link.rx_valid && !link.rx_err && tx_phase == TX_IDLE;
    assign tmo_lim = (tmo_set < `TIMEOUT_MIN) ? `TIMEOUT_FALLBACK : tmo_set;
    assign tx_start = send_req && tx_phase == TX_IDLE && rx_state != RX_BUSY &&
                      rx_state != RX_OFF;
    assign can_issue = !pend && !link.tx_go && !link.tx_busy;
    // Word mode splits low then high byte; byte mode takes low only
    assign tx_word = tx_mem[byte_mode ? tx_idx : {1'b0, tx_idx[7:1]}];
    assign tx_pick = (!byte_mode && tx_idx[0]) ? tx_word[15:8] : tx_word[7:0];

    assign link.fmt    = fmt_live;
    assign link.period = bit_cycles(fmt_live.rate);

    char_tx u_tx (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .link       (link.tx),
      .txd_o      (txd_o[p])
    );

    char_rx u_rx (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .rxd_i      (rxd_i[p]),
      .link       (link.rx)
    );

    // Software-written setup registers
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        fmt_reg <= `FORMAT_RST; enable <= 1'b0; byte_mode <= 1'b0;
        send_len <= 8'h00; recv_len <= 8'h00;
        start_ch <= `START_CHAR_RST; stop_ch <= `STOP_CHAR_RST;
        tmo_set <= `TIMEOUT_RST;
      end else begin
        if (wr_fmt) fmt_reg <= merge16(fmt_reg, wd, wb_sel_i[1:0]);
        if (wr_ctl && wb_sel_i[0]) begin
          enable    <= wd[`CTL_ENABLE];
          byte_mode <= wd[`CTL_BYTE_MODE];
        end
        if (hit && loc == `OFS_SEND_LEN && wb_sel_i[0]) send_len <= wd[7:0];
        if (hit && loc == `OFS_RECV_LEN && wb_sel_i[0]) recv_len <= wd[7:0];
        if (hit && loc == `OFS_START_CHAR && wb_sel_i[0]) start_ch <= wd[7:0];
        if (hit && loc == `OFS_STOP_CHAR && wb_sel_i[0]) stop_ch <= wd[7:0];
        if (hit && loc == `OFS_TIMEOUT && wb_sel_i[0]) tmo_set <= wd[7:0];
      end
    end

    // Source area, written by software
    always_ff @(posedge core_clk_i) begin
      if (hit && loc[11:10] == `AREA_TX) tx_mem[widx] <= merge16(tx_mem[widx], wd, wb_sel_i[1:0]);
    end

    // Receive sequencer with timeout
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        en_q <= 1'b0; fmt_live <= `FORMAT_RST; rx_state <= RX_OFF;
        recv_cnt <= 8'h00; timed_out <= 1'b0; presc <= 19'h0; ticks <= 8'h00;
      end else begin
        en_q <= enable;
        if (act) begin
          fmt_live <= fmt_reg;
          recv_cnt <= 8'h00;
          rx_state <= (recv_len != 8'h00) ? RX_WAIT : RX_OFF;
        end else if (!enable) begin
          rx_state <= RX_OFF;
        end else begin
          unique case (rx_state)
            RX_OFF: ;
            RX_WAIT: if (rx_ok) begin
              recv_cnt <= 8'h00;
              if (!fmt_live.start_char_en) begin
                recv_cnt <= 8'h01;
                rx_state <= (recv_len == 8'h01) ? RX_DONE : RX_BUSY;
              end else if (link.rx_byte == start_ch) begin
                rx_state <= RX_BUSY;
              end
            end
            RX_BUSY: if (rx_ok) begin
              if (fmt_live.stop_char_en && link.rx_byte == stop_ch) begin
                rx_state <= RX_DONE;
              end else begin
                recv_cnt <= recv_cnt + 8'd1;
                if (recv_cnt + 8'd1 == recv_len) rx_state <= RX_DONE;
              end
            end else if (ticks == tmo_lim) begin
              timed_out <= 1'b1;
              rx_state  <= RX_DONE;
            end
            RX_DONE: if (clr_done) begin
              timed_out <= 1'b0;
              recv_cnt  <= 8'h00;
              rx_state  <= RX_WAIT;
            end
          endcase
        end
        // 10 ms ticks restart on every accepted byte so only a pause counts
        if (rx_state != RX_BUSY || rx_ok) begin
          presc <= 19'h0;
          ticks <= 8'h00;
        end else if (presc == 19'(TICK_CYCLES - 1)) begin
          presc <= 19'h0;
          ticks <= ticks + 8'd1;
        end else begin
          presc <= presc + 19'd1;
        end
      end
    end

    // Destination area, filled as bytes arrive
    always_ff @(posedge core_clk_i) begin
      if (enable && rx_ok && (rx_state == RX_BUSY ||
          (rx_state == RX_WAIT && !fmt_live.start_char_en)) &&
          !(rx_state == RX_BUSY && fmt_live.stop_char_en && link.rx_byte == stop_ch)) begin
        if (byte_mode) begin
          rx_lo[recv_cnt] <= link.rx_byte;
          rx_hi[recv_cnt] <= 8'h00;
        end else if (recv_cnt[0]) begin
          rx_hi[{1'b0, recv_cnt[7:1]}] <= link.rx_byte;
        end else begin
          rx_lo[{1'b0, recv_cnt[7:1]}] <= link.rx_byte;
        end
      end
    end

    // Send sequencer: lead char, data, trail char
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        tx_phase <= TX_IDLE; send_req <= 1'b0; send_wait <= 1'b0;
        send_rem <= 8'h00; tx_idx <= 8'h00; pend <= 1'b0;
        link.tx_go <= 1'b0; link.tx_byte <= 8'h00; drive_en_o[p] <= 1'b0;
      end else begin
        link.tx_go <= 1'b0;
        if (link.tx_done) pend <= 1'b0;
        if (link.tx_go) pend <= 1'b1;
        if (req_set && rx_state == RX_BUSY) send_wait <= 1'b1;
        unique case (tx_phase)
          TX_IDLE: if (tx_start) begin
            send_wait <= 1'b0;
            send_rem  <= send_len;
            tx_idx    <= 8'h00;
            drive_en_o[p] <= 1'b1;
            tx_phase  <= fmt_live.start_char_en ? TX_LEAD : TX_BODY;
          end
          TX_LEAD: if (can_issue) begin
            link.tx_byte <= start_ch;
            link.tx_go   <= 1'b1;
            tx_phase     <= TX_BODY;
          end
          TX_BODY: if (can_issue) begin
            if (send_rem == 8'h00) begin
              tx_phase <= fmt_live.stop_char_en ? TX_TRAIL : TX_DRAIN;
            end else begin
              link.tx_byte <= tx_pick;
              link.tx_go   <= 1'b1;
              tx_idx       <= tx_idx + 8'd1;
              send_rem     <= send_rem - 8'd1;
            end
          end
          TX_TRAIL: if (can_issue) begin
            link.tx_byte <= stop_ch;
            link.tx_go   <= 1'b1;
            tx_phase     <= TX_DRAIN;
          end
          TX_DRAIN: if (can_issue) begin
            drive_en_o[p] <= 1'b0;
            tx_phase      <= TX_IDLE;
          end
        endcase
        // A new request in the finishing cycle wins over the clear
        if (req_set) send_req <= 1'b1;
        else if (tx_phase == TX_DRAIN && can_issue) send_req <= 1'b0;
      end
    end

    // Register and area readback
    assign port_rd[p] =
      (loc == `OFS_FORMAT)     ? {16'h0000, fmt_reg} :
      (loc == `OFS_CONTROL)    ? {29'h0, byte_mode, 1'b0, enable} :
      (loc == `OFS_STATUS)     ? {25'h0, tx_phase != TX_IDLE, rx_state == RX_BUSY,
                                  rx_state == RX_WAIT, timed_out, rx_state == RX_DONE,
                                  send_req, send_wait} :
      (loc == `OFS_SEND_LEN)   ? {24'h0, send_len} :
      (loc == `OFS_RECV_LEN)   ? {24'h0, recv_len} :
      (loc == `OFS_SEND_REM)   ? {24'h0, send_rem} :
      (loc == `OFS_RECV_CNT)   ? {24'h0, recv_cnt} :
      (loc == `OFS_START_CHAR) ? {24'h0, start_ch} :
      (loc == `OFS_STOP_CHAR)  ? {24'h0, stop_ch} :
      (loc == `OFS_TIMEOUT)    ? {24'h0, tmo_set} :
      (loc[11:10] == `AREA_TX) ? {16'h0000, tx_mem[widx]} :
      (loc[11:10] == `AREA_RX) ? {16'h0000, rx_hi[widx], rx_lo[widx]} :
                                 32'h0000_0000;
  end
endmodule
`default_nettype wire

// File: dv/sfft_chk.sv
/*
  Port-level checks of the free-format transfer block: bus handshake
  and line framing. Assumes one clock domain, async low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module sfft_chk #(
  parameter int unsigned TICK_CYCLES = 400000 // Cycles per 10 ms
) (
  input wire logic        core_clk_i, // Core clock
  input wire logic        nrst_i,     // Async reset, low
  input wire logic        wb_cyc_i,   // Bus cycle
  input wire logic        wb_stb_i,   // Bus strobe
  input wire logic        wb_we_i,    // Write enable
  input wire logic [12:0] wb_adr_i,   // Byte address
  input wire logic [31:0] wb_dat_i,   // Write data
  input wire logic [3:0]  wb_sel_i,   // Byte lanes
  input wire logic [31:0] wb_dat_o,   // Read data
  input wire logic        wb_ack_o,   // Acknowledge
  input wire logic [1:0]  rxd_i,      // Line in
  input wire logic [1:0]  txd_o,      // Line out
  input wire logic [1:0]  drive_en_o  // Driver enable
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // One wait state, then a single-cycle ack
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late or missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // Line framing; a start bit stays low for at least nine cycles
  a_idle_high: assert property (!drive_en_o[0] |-> txd_o[0])
    else $error("line low outside a frame");
  a_start_framed: assert property ($fell(txd_o[0]) |-> drive_en_o[0])
    else $error("start bit without driver");
  a_start_width: assert property ($fell(txd_o[0]) |=> !txd_o[0] [*8])
    else $error("start bit too short");
  a_frame_end: assert property ($fell(drive_en_o[0]) |-> $past(txd_o[0]))
    else $error("frame ended off a stop bit");
  a_card_idle: assert property (!drive_en_o[1] |-> txd_o[1])
    else $error("card line low outside a frame");
endmodule
bind serial_free_format_transfer sfft_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .core_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_dat_o, .wb_ack_o, .rxd_i, .txd_o, .drive_en_o
);
`default_nettype wire

// File: dv/remote_peer.sv
/*
  Remote serial peer, 8N1. Assumes the block's line idles high
  and bits last BIT_NS exactly.
*/
`timescale 1ns/10ps
`default_nettype none
module remote_peer #(
  parameter int BIT_NS = 3250 // One bit at 307200 bps
) (
  input  wire logic txd_i, // Line from the block
  output var  logic rxd_o  // Line into the block
);
  logic [7:0] rx_q [$];
  logic [7:0] b;
  initial rxd_o = 1'b1;
  // Mid-bit sampling, LSB first
  always @(negedge txd_i) begin
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      b[i] = txd_i;
    end
    #(BIT_NS);
    rx_q.push_back(b);
  end
  // Low start bit, LSB first, high stop bit left as idle
  task automatic send(input logic [7:0] d);
    rxd_o = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd_o = d[i];
      #(BIT_NS);
    end
    rxd_o = 1'b1;
    #(BIT_NS);
  endtask
endmodule
`default_nettype wire

// File: dv/serial_free_format_transfer_tb.sv
/*
  Bench of the free-format transfer block over classic Wishbone.
  Assumes remote_peer on the main line; card line looped back onto itself.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_free_format_transfer_tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [12:0] adr = 13'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [3:0] lanes = 4'hF;
  logic [31:0] rdat, q;
  logic ack, line_in;
  logic [1:0] txd, den;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] exp_tx [8] = '{8'h02, 8'h5A, 8'hA5, 8'h03, 8'h02, 8'h5A, 8'hA5, 8'h03};

  // 400-cycle tick: the 50 ms timeout is 2000 cycles, longer than one character
  serial_free_format_transfer #(.TICK_CYCLES(400)) dut_u (.core_clk_i, .nrst_i,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i({txd[1], line_in}),
    .txd_o(txd), .drive_en_o(den));
  remote_peer peer_u (.txd_i(txd[0]), .rxd_o(line_in));

  always #12.5 core_clk_i = ~core_clk_i;

  task automatic print_verdict;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic single cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [12:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (ack !== 1'b1 && k < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 40) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [12:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    check(nm, q, e);
  endtask
  // Status polling, bounded
  task automatic poll(input int b, input logic v);
    int k;
    for (k = 0; k < 400; k++) begin
      wb(1'b0, 13'h008, 32'h0);
      if (q[b] === v) break;
      repeat (50) @(posedge core_clk_i);
    end
    if (k == 400) begin
      failures++;
      print_verdict();
    end
  endtask

  // Main sequence: resets, send, receive by count, receive by timeout
  initial begin
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(13'h000, 32'h0, "format");
    rd(13'h01C, 32'h02, "start_char");
    rd(13'h020, 32'h03, "stop_char");
    rd(13'h024, 32'h05, "timeout");
    rd(13'h0FC, 32'h0, "unmapped");
    rd(13'h101C, 32'h02, "card_start");
    lanes = 4'h0;
    wb(1'b1, 13'h01C, 32'h55); // No lane selected, so ignored
    lanes = 4'hF;
    rd(13'h01C, 32'h02, "lane_mask");
    wb(1'b1, 13'h1004, 32'h1);
    rd(13'h1008, 32'h0, "card_zero_len");
    wb(1'b1, 13'h000, 32'h3E1); // 8N1, top rate, both chars, upper bits zero
    wb(1'b1, 13'h400, 32'hA55A);
    wb(1'b1, 13'h00C, 32'h2);
    wb(1'b1, 13'h010, 32'h2);
    wb(1'b1, 13'h004, 32'h1);
    rd(13'h008, 32'h10, "rx_waiting");
    wb(1'b1, 13'h004, 32'h3);
    wb(1'b1, 13'h000, 32'h0); // Must not alter the active format
    poll(1, 1'b0);
    check("drive_en", {30'h0, den}, 32'h0);
    rd(13'h014, 32'h0, "send_rem");
    peer_u.send(8'h02);
    peer_u.send(8'h3C);
    peer_u.send(8'h4B);
    poll(2, 1'b1);
    rd(13'h800, 32'h4B3C, "rx_word");
    rd(13'h018, 32'h2, "rx_count");
    wb(1'b1, 13'h008, 32'h4);
    rd(13'h008, 32'h10, "rearm");
    peer_u.send(8'h02);
    fork
      peer_u.send(8'h11);
      begin
        repeat (1000) @(posedge core_clk_i);
        wb(1'b1, 13'h004, 32'h3);
        wb(1'b0, 13'h008, 32'h0);
        check("send_wait", {31'h0, q[0]}, 32'h1);
      end
    join
    poll(3, 1'b1);
    poll(1, 1'b0);
    rd(13'h008, 32'h0C, "timeout_done");
    rd(13'h018, 32'h1, "rx_partial");
    wb(1'b1, 13'h008, 32'h4);
    rd(13'h008, 32'h10, "timeout_clear");
    check("tx_count", 32'(peer_u.rx_q.size()), 32'h8);
    foreach (exp_tx[i]) check("tx_byte", {24'h0, peer_u.rx_q[i]}, {24'h0, exp_tx[i]});
    print_verdict();
  end
endmodule
`default_nettype wire
